// >>> logic/spiprg_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Master toward EEPROM, slave in programming mode
// - Clock pin output as master, input as slave
// - One byte each way per transfer, circular
// - Eight clocks swap master and slave contents
// - EEPROM select comes from a separate GPIO
// - Port not offered to application software
// - Reset held low full count, then accept entry
// - Enter programming after both entry bytes accepted
// - Slave-out pin drives once programming entered
// - Stay programming while reset pin stays low
// - Reset pin high: master reset pulse, then run
// - Watchdog disabled during programming mode
// - Other GPIO pins tri-stated while programming
// - Flash erase, read, write done for master
// - Identity, protection and home identifier commands served
// - Reset pin synchronised to the crystal clock
// - All GPIOs inputs during master reset
module spiprg_top #(
    parameter int unsigned ENTRY_CYC   = spiprg_pkg::ENTRY_CYC_DEFAULT,
    parameter logic [7:0]  ENTRY_BYTE0 = 8'hA5,
    parameter logic [7:0]  ENTRY_BYTE1 = 8'h5A
) (
    input  wire logic       ref_clk,
    input  wire logic       arst_n,

    input  wire logic       ext_reset_n_pin,

    input  wire logic       port1_bit4_serial_clock_pin_i,
    output var  logic       port1_bit4_serial_clock_pin_o,
    output var  logic       port1_bit4_serial_clock_pin_oe_n,

    input  wire logic       port1_bit3_master_out_pin_i,
    output var  logic       port1_bit3_master_out_pin_o,
    output var  logic       port1_bit3_master_out_pin_oe_n,

    input  wire logic       port1_bit2_slave_out_pin_i,
    output var  logic       port1_bit2_slave_out_pin_o,
    output var  logic       port1_bit2_slave_out_pin_oe_n,

    input  wire logic       ee_start,
    input  wire logic [7:0] ee_tx_byte,
    output var  logic       ee_busy,

    input  wire logic [7:0] reply_byte,

    output var  logic [7:0] rx_data,
    output var  logic       rx_valid,
    input  wire logic       rx_ready,

    output var  logic       overrun,

    output var  logic       prog_mode,
    output var  logic       master_reset,

    output var  logic       wdt_disable,
    output var  logic       gpio_hiz,
    output var  logic       gpio_all_input
);
    localparam logic [17:0] ENTRY_LAST = 18'(ENTRY_CYC - 1);

    spiprg_pkg::spiprg_state_t s_r;
    spiprg_pkg::spiprg_state_t s_nxt;
    spiprg_fifo_if #(.WIDTH(spiprg_pkg::BYTE_W)) fifo_bus ();

    logic       sck_rise;
    logic       sck_fall;
    logic       slave_active;
    logic       byte_done;
    logic [7:0] byte_in;

    // A pin change counts once the second and third stages agree
    function automatic logic agree(input logic [2:0] sync, input logic lvl);
        agree = (sync[1] == sync[2]) ? sync[2] : lvl;
    endfunction

    // Received bytes leave through the FIFO
    assign fifo_bus.wr_valid = s_r.push_valid;
    assign fifo_bus.wr_data  = s_r.push_data;
    assign fifo_bus.rd_ready = rx_ready;
    assign rx_valid          = fifo_bus.rd_valid;
    assign rx_data           = fifo_bus.rd_data;

    spiprg_fifo #(
        .WIDTH (spiprg_pkg::BYTE_W),
        .DEPTH (spiprg_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .fifo    (fifo_bus.store)
    );

    // Next-state logic for the whole port
    always_comb
    begin
        s_nxt        = s_r;
        sck_rise     = 1'b0;
        sck_fall     = 1'b0;
        slave_active = 1'b0;
        byte_done    = 1'b0;
        byte_in      = '0;

        // Pin synchronisers; stage 0 is read only by stage 1
        s_nxt.rstn_s   = {s_r.rstn_s[1:0], ext_reset_n_pin};
        s_nxt.sck_s    = {s_r.sck_s[1:0], port1_bit4_serial_clock_pin_i};
        s_nxt.mosi_s   = {s_r.mosi_s[1:0], port1_bit3_master_out_pin_i};
        s_nxt.miso_s   = {s_r.miso_s[1:0], port1_bit2_slave_out_pin_i};

        s_nxt.rstn_lvl = agree(s_r.rstn_s, s_r.rstn_lvl);
        s_nxt.sck_lvl  = agree(s_r.sck_s, s_r.sck_lvl);
        s_nxt.mosi_lvl = agree(s_r.mosi_s, s_r.mosi_lvl);
        s_nxt.miso_lvl = agree(s_r.miso_s, s_r.miso_lvl);

        sck_rise       = s_nxt.sck_lvl && !s_r.sck_lvl;
        sck_fall       = !s_nxt.sck_lvl && s_r.sck_lvl;

        // A pending byte leaves once the FIFO takes it
        if (s_r.push_valid && fifo_bus.wr_ready)
        begin
            s_nxt.push_valid = 1'b0;
        end

        // Slave shifter: sample on rise, launch on fall
        slave_active = (s_r.mode == spiprg_pkg::SPIPRG_ARMED) ||
                       (s_r.mode == spiprg_pkg::SPIPRG_PROG);

        if (slave_active && s_r.rstn_lvl == 1'b0)
        begin
            if (sck_rise)
            begin
                byte_in       = {s_r.shreg[6:0], s_nxt.mosi_lvl};
                s_nxt.shreg   = byte_in;
                s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
                byte_done     = (s_r.bit_cnt == spiprg_pkg::BIT_LAST);
            end
            else if (sck_fall)
            begin
                s_nxt.miso_o = s_r.shreg[7];
            end
        end

        unique case (s_r.mode)
            spiprg_pkg::SPIPRG_NORMAL:
            begin
                if (!s_r.rstn_lvl)
                begin
                    // Reset pin went low: drop any master transfer
                    s_nxt.mode    = spiprg_pkg::SPIPRG_WAIT;
                    s_nxt.ent_cnt = '0;
                    s_nxt.m_busy  = 1'b0;
                    s_nxt.sck_o   = 1'b0;
                end
                else if (s_r.m_busy)
                begin
                    // Master drives its own clock
                    s_nxt.m_div = s_r.m_div + 1'b1;
                    if (s_r.m_div == spiprg_pkg::SCK_HALF_LAST)
                    begin
                        s_nxt.m_div = '0;
                        if (!s_r.sck_o)
                        begin
                            s_nxt.sck_o   = 1'b1;
                            s_nxt.shreg   = {s_r.shreg[6:0], s_nxt.miso_lvl};
                            s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
                            if (s_r.bit_cnt == spiprg_pkg::BIT_LAST)
                            begin
                                s_nxt.m_last     = 1'b1;
                                s_nxt.push_valid = 1'b1;
                                s_nxt.push_data  = {s_r.shreg[6:0], s_nxt.miso_lvl};
                            end
                        end
                        else
                        begin
                            s_nxt.sck_o = 1'b0;
                            if (s_r.m_last)
                                s_nxt.m_busy = 1'b0;
                            else
                                s_nxt.mosi_o = s_r.shreg[7];
                        end
                    end
                end
                else if (ee_start && !s_r.push_valid)
                begin
                    // Start waits for the last byte to leave
                    s_nxt.m_busy  = 1'b1;
                    s_nxt.m_last  = 1'b0;
                    s_nxt.m_div   = '0;
                    s_nxt.bit_cnt = '0;
                    s_nxt.shreg   = ee_tx_byte;
                    s_nxt.mosi_o  = ee_tx_byte[7];
                end
            end

            spiprg_pkg::SPIPRG_WAIT:
            begin
                if (s_r.rstn_lvl)
                begin
                    s_nxt.mode = spiprg_pkg::SPIPRG_NORMAL;
                end
                else if (s_r.ent_cnt == ENTRY_LAST)
                begin
                    // Count done: listen for entry
                    s_nxt.mode       = spiprg_pkg::SPIPRG_ARMED;
                    s_nxt.bit_cnt    = '0;
                    s_nxt.entry_half = 1'b0;
                    s_nxt.shreg      = '0;
                    s_nxt.overrun    = 1'b0;
                end
                else
                begin
                    s_nxt.ent_cnt = s_r.ent_cnt + 1'b1;
                end
            end

            spiprg_pkg::SPIPRG_ARMED:
            begin
                if (s_r.rstn_lvl)
                begin
                    s_nxt.mode = spiprg_pkg::SPIPRG_NORMAL;
                end
                else if (byte_done)
                begin
                    // Both entry bytes must match in sequence
                    if (!s_r.entry_half)
                    begin
                        s_nxt.entry_half = (byte_in == ENTRY_BYTE0);
                    end
                    else if (byte_in == ENTRY_BYTE1)
                    begin
                        s_nxt.mode  = spiprg_pkg::SPIPRG_PROG;
                        s_nxt.shreg = reply_byte;
                    end
                    else
                    begin
                        s_nxt.entry_half = (byte_in == ENTRY_BYTE0);
                    end
                end
            end

            spiprg_pkg::SPIPRG_PROG:
            begin
                if (s_r.rstn_lvl)
                begin
                    s_nxt.mode     = spiprg_pkg::SPIPRG_MRST;
                    s_nxt.mrst_cnt = '0;
                end
                else if (byte_done)
                begin
                    // Byte to the flash engine, its reply loaded
                    s_nxt.shreg = reply_byte;
                    if (s_r.push_valid && !fifo_bus.wr_ready)
                    begin
                        s_nxt.overrun = 1'b1;
                    end
                    else
                    begin
                        s_nxt.push_valid = 1'b1;
                        s_nxt.push_data  = byte_in;
                    end
                end
            end

            spiprg_pkg::SPIPRG_MRST:
            begin
                // Fixed master reset pulse, then run
                s_nxt.mrst_cnt = s_r.mrst_cnt + 1'b1;
                if (s_r.mrst_cnt == spiprg_pkg::MRST_LAST)
                begin
                    s_nxt.mode   = spiprg_pkg::SPIPRG_NORMAL;
                    s_nxt.sck_o  = 1'b0;
                    s_nxt.m_busy = 1'b0;
                end
            end

            default:
            begin
                s_nxt.mode = spiprg_pkg::SPIPRG_NORMAL;
            end
        endcase

        // Pin enables, from the next mode
        s_nxt.sck_oe_n       = (s_nxt.mode != spiprg_pkg::SPIPRG_NORMAL);
        s_nxt.mosi_oe_n      = (s_nxt.mode != spiprg_pkg::SPIPRG_NORMAL);
        s_nxt.miso_oe_n      = (s_nxt.mode != spiprg_pkg::SPIPRG_PROG);

        // Mode flags
        s_nxt.prog_mode      = (s_nxt.mode == spiprg_pkg::SPIPRG_PROG);
        s_nxt.gpio_hiz       = (s_nxt.mode == spiprg_pkg::SPIPRG_PROG);

        // Master reset flags
        s_nxt.master_reset   = (s_nxt.mode != spiprg_pkg::SPIPRG_NORMAL) &&
                               (s_nxt.mode != spiprg_pkg::SPIPRG_PROG);
        s_nxt.gpio_all_input = s_nxt.master_reset;

        // Busy covers master traffic only
        s_nxt.ee_busy        = s_nxt.m_busy ||
                               (s_nxt.push_valid && s_nxt.mode == spiprg_pkg::SPIPRG_NORMAL);
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r           <= '0;

            s_r.rstn_s    <= spiprg_pkg::SYNC_RST_HIGH;
            s_r.rstn_lvl  <= 1'b1;
            s_r.sck_s     <= spiprg_pkg::SYNC_RST_LOW;
            s_r.sck_oe_n  <= 1'b0;
            s_r.mosi_oe_n <= 1'b0;
            s_r.miso_oe_n <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // No slave select here: the EEPROM select is an ordinary GPIO
    // No registers for software; EEPROM and programming only
    assign port1_bit4_serial_clock_pin_o    = s_r.sck_o;
    assign port1_bit4_serial_clock_pin_oe_n = s_r.sck_oe_n;
    assign port1_bit3_master_out_pin_o      = s_r.mosi_o;
    assign port1_bit3_master_out_pin_oe_n   = s_r.mosi_oe_n;
    assign port1_bit2_slave_out_pin_o       = s_r.miso_o;
    assign port1_bit2_slave_out_pin_oe_n    = s_r.miso_oe_n;

    // Status outputs
    assign ee_busy                          = s_r.ee_busy;
    assign overrun                          = s_r.overrun;
    assign prog_mode                        = s_r.prog_mode;
    assign master_reset                     = s_r.master_reset;
    assign wdt_disable                      = s_r.prog_mode;
    assign gpio_hiz                         = s_r.gpio_hiz;
    assign gpio_all_input                   = s_r.gpio_all_input;
endmodule
`default_nettype wire

// >>> logic/spiprg_pkg.sv
`default_nettype none
package spiprg_pkg;

    // Reference clock and crystal timing
    localparam int unsigned CLK_PERIOD_NS        = 50;
    localparam int unsigned CRYSTAL_PERIOD_NS    = 50;
    localparam int unsigned ENTRY_CRYSTAL_CLOCK_PERIOD_PERIODS   = 131072;
    localparam int unsigned ENTRY_CYC_DEFAULT    =
        (ENTRY_CRYSTAL_CLOCK_PERIOD_PERIODS * CRYSTAL_PERIOD_NS) / CLK_PERIOD_NS;

    // Master reset pulse, rounded up
    localparam int unsigned MRST_PULSE_NS        = 800;
    localparam int unsigned MRST_PULSE_CYC       =
        (MRST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0]  MRST_LAST            = 5'(MRST_PULSE_CYC - 1);

    // Master serial clock half period, rounded down
    localparam int unsigned SCK_HALF_NS          = 200;
    localparam int unsigned SCK_HALF_CYC         = SCK_HALF_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  SCK_HALF_LAST        = 4'(SCK_HALF_CYC - 1);

    // Byte layout
    localparam int unsigned BYTE_W               = 8;
    localparam logic [2:0]  BIT_LAST             = 3'h7;
    localparam int unsigned FIFO_DEPTH           = 8;

    // Reset values
    localparam logic [2:0]  SYNC_RST_HIGH        = 3'h7;
    localparam logic [2:0]  SYNC_RST_LOW         = 3'h0;

    // Operating mode, Gray coded
    typedef enum logic [2:0] {
        SPIPRG_NORMAL = 3'h0,
        SPIPRG_WAIT   = 3'h1,
        SPIPRG_ARMED  = 3'h3,
        SPIPRG_PROG   = 3'h2,
        SPIPRG_MRST   = 3'h6
    } spiprg_mode_t;

    // Entire state of the top module
    typedef struct packed {
        spiprg_mode_t mode;
        logic [2:0]   rstn_s;
        logic [2:0]   sck_s;
        logic [2:0]   mosi_s;
        logic [2:0]   miso_s;
        logic         rstn_lvl;
        logic         sck_lvl;
        logic         mosi_lvl;
        logic         miso_lvl;
        logic [17:0]  ent_cnt;
        logic [4:0]   mrst_cnt;
        logic [7:0]   shreg;
        logic [2:0]   bit_cnt;
        logic         entry_half;
        logic         m_busy;
        logic         m_last;
        logic [3:0]   m_div;
        logic         sck_o;
        logic         mosi_o;
        logic         miso_o;
        logic         sck_oe_n;
        logic         mosi_oe_n;
        logic         miso_oe_n;
        logic         push_valid;
        logic [7:0]   push_data;
        logic         ee_busy;
        logic         overrun;
        logic         prog_mode;
        logic         master_reset;
        logic         gpio_hiz;
        logic         gpio_all_input;
    } spiprg_state_t;

endpackage
`default_nettype wire

// >>> logic/spiprg_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
// Byte stream between the serial port and its receive FIFO
interface spiprg_fifo_if #(
    parameter int unsigned WIDTH = 8
);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport push (
        output wr_valid,
        output wr_data,
        input  wr_ready,
        input  rd_valid,
        input  rd_data,
        output rd_ready
    );

    modport store (
        input  wr_valid,
        input  wr_data,
        output wr_ready,
        output rd_valid,
        output rd_data,
        input  rd_ready
    );
endinterface
`default_nettype wire

// >>> logic/spiprg_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Small FIFO with a registered output word
module spiprg_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic      ref_clk,
    input  wire logic      arst_n,
    spiprg_fifo_if.store   fifo
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
        logic                        out_valid;
        logic [WIDTH-1:0]            out_data;
    } spiprg_fifo_state_t;

    spiprg_fifo_state_t s_r;
    spiprg_fifo_state_t s_nxt;
    logic               do_wr;
    logic               do_rd;

    // Full and empty come from the stored count
    assign fifo.wr_ready = (s_r.count != (AW+1)'(DEPTH));
    assign fifo.rd_valid = s_r.out_valid;
    assign fifo.rd_data  = s_r.out_data;

    // Pointer and output stage update
    always_comb
    begin
        s_nxt = s_r;
        do_wr = fifo.wr_valid && fifo.wr_ready;
        do_rd = (s_r.count != '0) && (!s_r.out_valid || fifo.rd_ready);
        if (s_r.out_valid && fifo.rd_ready)
        begin
            s_nxt.out_valid = 1'b0;
        end
        if (do_rd)
        begin
            s_nxt.out_valid = 1'b1;
            s_nxt.out_data  = s_r.mem[s_r.rptr];
            s_nxt.rptr      = s_r.rptr + 1'b1;
        end
        if (do_wr)
        begin
            s_nxt.mem[s_r.wptr] = fifo.wr_data;
            s_nxt.wptr          = s_r.wptr + 1'b1;
        end
        s_nxt.count = s_r.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule
`default_nettype wire

// >>> testbench/spiprg_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Pin ownership, mode flags, reset timing
module spiprg_top_checker #(
    parameter int unsigned ENTRY_CYC = 512
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic ext_reset_n_pin,
    input wire logic port1_bit4_serial_clock_pin_o,
    input wire logic port1_bit4_serial_clock_pin_oe_n,
    input wire logic port1_bit3_master_out_pin_o,
    input wire logic port1_bit3_master_out_pin_oe_n,
    input wire logic port1_bit2_slave_out_pin_oe_n,
    input wire logic ee_busy,
    input wire logic prog_mode,
    input wire logic master_reset,
    input wire logic wdt_disable,
    input wire logic gpio_hiz,
    input wire logic gpio_all_input
);
    logic [19:0] low_cnt_r;
    logic [5:0]  hi_cnt_r;
    logic        from_prog_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // Low-pin and pulse run lengths
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_cnt_r   <= 20'h0;
            hi_cnt_r    <= 6'h0;
            from_prog_r <= 1'b0;
        end
        else
        begin
            low_cnt_r   <= ext_reset_n_pin ? 20'h0 : low_cnt_r + 20'h1;
            hi_cnt_r    <= master_reset ? hi_cnt_r + 6'h1 : 6'h0;
            from_prog_r <= prog_mode | (from_prog_r & master_reset);
        end
    end

    // Pin directions by mode
    master_drive_a: assert property (
        ee_busy |-> !port1_bit4_serial_clock_pin_oe_n && !port1_bit3_master_out_pin_oe_n)
        else $error("master pins");
    slave_drive_a: assert property (
        prog_mode |-> !port1_bit2_slave_out_pin_oe_n && port1_bit4_serial_clock_pin_oe_n)
        else $error("slave pins");
    wdt_off_a: assert property (wdt_disable == prog_mode)
        else $error("watchdog");
    gpio_hiz_a: assert property (gpio_hiz == prog_mode)
        else $error("tri-state");
    all_input_a: assert property (gpio_all_input == master_reset)
        else $error("all input");
    // Programming entry and exit
    prog_hold_a: assert property (
        (!ext_reset_n_pin) [*4] ##0 prog_mode |=> prog_mode)
        else $error("left early");
    entry_count_a: assert property ($rose(prog_mode) |-> low_cnt_r >= ENTRY_CYC)
        else $error("early entry");
    exit_pulse_a: assert property ($fell(prog_mode) |-> ##[0:2] master_reset)
        else $error("no exit pulse");
    pulse_len_a: assert property (
        $fell(master_reset) && from_prog_r |-> hi_cnt_r == spiprg_pkg::MRST_PULSE_CYC)
        else $error("pulse length");
    // Master clock and data
    sck_idle_a: assert property (
        !ee_busy && !port1_bit4_serial_clock_pin_oe_n |-> !port1_bit4_serial_clock_pin_o)
        else $error("clock idle");
    sck_phase_a: assert property (
        $rose(ee_busy) |-> !port1_bit4_serial_clock_pin_o [*4] ##1 port1_bit4_serial_clock_pin_o)
        else $error("first edge");
    mosi_hold_a: assert property (
        ee_busy && port1_bit4_serial_clock_pin_o |-> $stable(port1_bit3_master_out_pin_o))
        else $error("data moved");

    // Main scenarios reached
    cover property ($rose(prog_mode));
    cover property ($fell(master_reset) && from_prog_r);
    cover property ($rose(ee_busy));
endmodule

bind spiprg_top spiprg_top_checker #(.ENTRY_CYC(ENTRY_CYC)) i_chk (.*);
`default_nettype wire

// >>> testbench/spiprg_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: EEPROM slave, programming master
module spiprg_partner #(
    parameter logic [7:0] EE_INIT = 8'h96
) (
    input  wire logic sck_pin,
    input  wire logic mosi_pin,
    input  wire logic miso_pin,
    input  wire logic sel_n,
    output var  logic sck_drv,
    output var  logic mosi_drv,
    output wire logic miso_drv
);
    logic [7:0] ee_sh  = EE_INIT;
    logic       ee_bit = 1'b0;

    // Programming clock stands low outside frames
    initial
    begin
        sck_drv  = 1'b0;
        mosi_drv = 1'b0;
    end

    // EEPROM: sample on rise, shift on fall
    always @(posedge sck_pin) ee_bit = mosi_pin;
    always @(negedge sck_pin) if (!sel_n) ee_sh = {ee_sh[6:0], ee_bit};
    assign miso_drv = sel_n ? ~ee_sh[7] : ee_sh[7];  // Deselected: inverse of bit 7

    // Programming unit byte, 400 ns clock
    task automatic send(input logic [7:0] tx, output logic [7:0] rx);
        #13;
        for (int i = 7; i >= 0; i--)
        begin
            mosi_drv = tx[i];
            #200 sck_drv = 1'b1;
            rx[i] = miso_pin;
            #200 sck_drv = 1'b0;
        end
        mosi_drv = ~tx[0];
    endtask
endmodule
`default_nettype wire

// >>> testbench/spiprg_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module spiprg_top_test;
    localparam int unsigned ENT = 512;
    int         err_total  = 0;
    int         n_compared = 0;
    logic       ref_clk, arst_n, ext_reset_n_pin, ee_start, rx_ready, ee_sel_n;
    logic [7:0] ee_tx_byte, reply_byte, rx_data, got;
    logic       ee_busy, rx_valid, overrun, prog_mode, master_reset;
    logic       wdt_disable, gpio_hiz, gpio_all_input;
    logic       port1_bit4_serial_clock_pin_o, port1_bit4_serial_clock_pin_oe_n;
    logic       port1_bit3_master_out_pin_o, port1_bit3_master_out_pin_oe_n;
    logic       port1_bit2_slave_out_pin_o, port1_bit2_slave_out_pin_oe_n;
    wire        p_sck, p_mosi, p_miso, sck, mosi, miso;

    // Pin carries its driver
    assign sck  = port1_bit4_serial_clock_pin_oe_n ? p_sck : port1_bit4_serial_clock_pin_o;
    assign mosi = port1_bit3_master_out_pin_oe_n ? p_mosi : port1_bit3_master_out_pin_o;
    assign miso = port1_bit2_slave_out_pin_oe_n ? p_miso : port1_bit2_slave_out_pin_o;

    spiprg_top #(.ENTRY_CYC(ENT)) i_dut (
        .*,
        .port1_bit4_serial_clock_pin_i (sck),
        .port1_bit3_master_out_pin_i   (mosi),
        .port1_bit2_slave_out_pin_i    (miso)
    );
    spiprg_partner i_far (
        .sck_pin  (sck),
        .mosi_pin (mosi),
        .miso_pin (miso),
        .sel_n    (ee_sel_n),
        .sck_drv  (p_sck),
        .mosi_drv (p_mosi),
        .miso_drv (p_miso)
    );

    // Counted comparison
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            err_total++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // One master byte; done low if busy stays
    task automatic ee_byte(input logic [7:0] tx, output logic done);
        int n;
        ee_tx_byte = tx;
        ee_start   = 1'b1;
        @(negedge ref_clk);
        ee_start = 1'b0;
        for (n = 0; n < 4 && ee_busy !== 1'b1; n++) @(negedge ref_clk);
        for (n = 0; n < 100 && ee_busy !== 1'b0; n++) @(negedge ref_clk);
        done = (ee_busy === 1'b0);
    endtask

    // Check and accept the FIFO head
    task automatic pop(input logic [7:0] exp);
        int n;
        for (n = 0; n < 300 && rx_valid !== 1'b1; n++) @(negedge ref_clk);
        chk(rx_data === exp, "received byte");
        rx_ready = 1'b1;
        @(negedge ref_clk);
        rx_ready = 1'b0;
    endtask

    // Ten bytes into a full FIFO, then drain it
    task automatic t_fifo;
        logic [7:0] tx [10];
        logic       done;
        ee_sel_n = 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            tx[i] = 8'(i * 37 + 58);
            ee_byte(tx[i], done);
            chk(done === (i < 9), "FIFO room");
        end
        for (int i = 0; i < 10; i++)
            pop(i == 0 ? 8'h96 : tx[i - 1]);
        repeat (4) @(negedge ref_clk);
        chk(ee_busy === 1'b0 && i_far.ee_sh === tx[9], "EEPROM");
        ee_sel_n = 1'b1;
        $display("t_fifo finished");
    endtask

    // Early release clears the entry count
    task automatic t_early;
        ext_reset_n_pin = 1'b0;
        repeat (100) @(negedge ref_clk);
        i_far.send(8'hA5, got);
        i_far.send(8'h5A, got);
        @(negedge ref_clk);
        chk(prog_mode === 1'b0 && gpio_all_input === 1'b1, "entry before count");
        ext_reset_n_pin = 1'b1;
        repeat (10) @(negedge ref_clk);
        ext_reset_n_pin = 1'b0;
        repeat (300) @(negedge ref_clk);
        i_far.send(8'hA5, got);
        i_far.send(8'h5A, got);
        repeat (10) @(negedge ref_clk);
        chk(prog_mode === 1'b0, "count kept");
        ext_reset_n_pin = 1'b1;
        repeat (40) @(negedge ref_clk);
        $display("t_early finished");
    endtask

    // Entry, two bytes with replies
    task automatic t_prog;
        ext_reset_n_pin = 1'b0;
        repeat (ENT + 20) @(negedge ref_clk);
        i_far.send(8'hA5, got);
        @(negedge ref_clk);
        chk(prog_mode === 1'b0, "one byte");
        i_far.send(8'h5A, got);
        repeat (4) @(negedge ref_clk);
        chk(prog_mode === 1'b1 && port1_bit2_slave_out_pin_oe_n === 1'b0, "entry");
        chk(wdt_disable && gpio_hiz && master_reset === 1'b0 && overrun === 1'b0, "flags");
        reply_byte = 8'h3C;
        i_far.send(8'h81, got);
        chk(got === 8'hC3, "first reply");
        pop(8'h81);
        i_far.send(8'h7E, got);
        chk(got === 8'h3C, "second reply");
        pop(8'h7E);
        chk(prog_mode === 1'b1, "left early");
        $display("t_prog finished");
    endtask

    // Release: master reset pulse, then normal run
    task automatic t_exit;
        int n;
        ext_reset_n_pin = 1'b1;
        for (n = 0; n < 10 && master_reset !== 1'b1; n++) @(negedge ref_clk);
        chk(gpio_all_input === 1'b1 && prog_mode === 1'b0, "exit pulse");
        for (n = 0; n < 40 && master_reset === 1'b1; n++) @(negedge ref_clk);
        chk(n == spiprg_pkg::MRST_PULSE_CYC, "pulse length");
        chk(port1_bit4_serial_clock_pin_oe_n === 1'b0, "pins back");
        $display("t_exit finished");
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Hang guard
    initial
    begin
        #400_000;
        err_total++;
        $display("unexpected at %0t: timeout", $time);
        final_report();
    end

    // Reset, then the scenarios
    initial
    begin
        arst_n          = 1'b0;
        ext_reset_n_pin = 1'b1;
        ee_start        = 1'b0;
        ee_tx_byte      = 8'h00;
        reply_byte      = 8'hC3;
        rx_ready        = 1'b0;
        ee_sel_n        = 1'b1;
        repeat (6) @(negedge ref_clk);
        arst_n = 1'b1;
        t_fifo();
        t_early();
        t_prog();
        t_exit();
        final_report();
    end
endmodule
`default_nettype wire
